// ### design/pin_edge_cell.sv
`timescale 1ns/1ps
module pin_edge_cell (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pin and enables
	input wire logic pin_async,
	input wire logic rise_en,
	input wire logic fall_en,
	// Detected edge pulses
	output logic rise_p,
	output logic fall_p
);
	logic s1_q;
	logic s2_q;
	logic prev_q;

	// Two flops before any logic reads the pin
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			s1_q <= pin_async;
			s2_q <= s1_q;
			prev_q <= s2_q;
		end
	end

	assign rise_p = rise_en && s2_q && !prev_q;
	assign fall_p = fall_en && !s2_q && prev_q;
endmodule

// ### design/portb_edge_change_detect.sv
// Contract
// - Rising edge on pins 7..4 with rise enable sets pin flag and shared flag.
// - Falling edge on pins 7..4 with fall enable sets pin flag and shared flag.
// - Disabled polarity is ignored; both enables zero turn detection off.
// - Pin flag set only by an enabled edge, then stays set.
// - Software writes zero to clear a flag; reads zero until next edge.
// - Bits 3..0 of enable and flag registers ignore writes, read zero.
// - All enable and flag bits reset to zero on every reset.
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
module portb_edge_change_detect (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESET_N,
	// Port pins 7..4
	input wire logic [3:0] UPPER_PORT_PIN,
	// Register port
	input wire logic [2:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// Interrupt
	output logic IRQ
);
	logic [3:0] rise_edge_enable_bits_q;
	logic [3:0] fall_edge_enable_bits_q;
	logic [3:0] pin_change_flags_q;
	logic [3:0] pin_change_flags_d;
	logic shared_change_irq_enable_q;
	logic shared_change_irq_flag;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_en_q;
	logic [3:0] rise_p;
	logic [3:0] fall_p;
	logic [3:0] hit;
	logic [7:0] rdata_d;
	logic hit_any_q;
	logic [1:0] irq_stat_d;
	// Write decodes, one per register
	logic wr_rise_en;
	logic wr_fall_en;
	logic wr_flags;
	logic wr_ctrl;
	logic wr_irq_en;
	logic wr_irq_clr;

	genvar gi;
	generate
		for (gi = 0; gi < portb_edge_pkg::PIN_N; gi++) begin : g_pin
			pin_edge_cell pin_edge_cell_i (
				.clk(MCLK),
				.rst_n(RESET_N),
				.pin_async(UPPER_PORT_PIN[gi]),
				.rise_en(rise_edge_enable_bits_q[gi]),
				.fall_en(fall_edge_enable_bits_q[gi]),
				.rise_p(rise_p[gi]),
				.fall_p(fall_p[gi])
			);

			// Per-pin flag behaviour
			property p_pin_rise;
				@(posedge MCLK) disable iff (!RESET_N) rise_p[gi] |=> pin_change_flags_q[gi];
			endproperty
			a_pin_rise: assert property (p_pin_rise) else $error("pin rise lost");
			property p_pin_fall;
				@(posedge MCLK) disable iff (!RESET_N) fall_p[gi] |=> pin_change_flags_q[gi];
			endproperty
			a_pin_fall: assert property (p_pin_fall) else $error("pin fall lost");
			property p_pin_sticky;
				@(posedge MCLK) disable iff (!RESET_N)
				pin_change_flags_q[gi] && !(wr_flags && !WDATA[portb_edge_pkg::PIN_LO + gi])
				|=> pin_change_flags_q[gi];
			endproperty
			a_pin_sticky: assert property (p_pin_sticky) else $error("flag dropped");
			property p_pin_quiet;
				@(posedge MCLK) disable iff (!RESET_N)
				!pin_change_flags_q[gi] && !hit[gi] |=> !pin_change_flags_q[gi];
			endproperty
			a_pin_quiet: assert property (p_pin_quiet) else $error("flag without edge");
			property p_pin_clear;
				@(posedge MCLK) disable iff (!RESET_N)
				wr_flags && !WDATA[portb_edge_pkg::PIN_LO + gi] && !hit[gi]
				|=> !pin_change_flags_q[gi];
			endproperty
			a_pin_clear: assert property (p_pin_clear) else $error("pin clear failed");
			property p_pin_off;
				@(posedge MCLK) disable iff (!RESET_N)
				!rise_edge_enable_bits_q[gi] && !fall_edge_enable_bits_q[gi] |-> !hit[gi];
			endproperty
			a_pin_off: assert property (p_pin_off) else $error("pin edge while off");
		end
	endgenerate

	assign hit = rise_p | fall_p;

	// Strobes are one cycle, so a plain AND is enough for each decode
	assign wr_rise_en = WR && ADDR == portb_edge_pkg::OFF_RISE_EN;
	assign wr_fall_en = WR && ADDR == portb_edge_pkg::OFF_FALL_EN;
	assign wr_flags = WR && ADDR == portb_edge_pkg::OFF_FLAGS;
	assign wr_ctrl = WR && ADDR == portb_edge_pkg::OFF_CTRL;
	assign wr_irq_en = WR && ADDR == portb_edge_pkg::OFF_IRQ_EN;
	assign wr_irq_clr = WR && ADDR == portb_edge_pkg::OFF_IRQ_CLR;

	// Enable registers; rise and fall enables do not store the low nibble, the control enable stores bit 0
	always_ff @(posedge MCLK) begin
		if (!RESET_N)
			rise_edge_enable_bits_q <= portb_edge_pkg::RESET_VAL[7:4];
		else if (wr_rise_en)
			rise_edge_enable_bits_q <= WDATA[7:4];
	end

	always_ff @(posedge MCLK) begin
		if (!RESET_N)
			fall_edge_enable_bits_q <= portb_edge_pkg::RESET_VAL[7:4];
		else if (wr_fall_en)
			fall_edge_enable_bits_q <= WDATA[7:4];
	end

	always_ff @(posedge MCLK) begin
		if (!RESET_N)
			shared_change_irq_enable_q <= 1'b0;
		else if (wr_ctrl)
			shared_change_irq_enable_q <= WDATA[portb_edge_pkg::CTRL_IRQ_EN_BIT];
	end

	// Writing zero clears a flag; a same-cycle edge wins over the clear
	always_comb begin
		pin_change_flags_d = pin_change_flags_q;
		if (wr_flags)
			pin_change_flags_d = pin_change_flags_q & WDATA[7:4];
		pin_change_flags_d = pin_change_flags_d | hit;
	end

	always_ff @(posedge MCLK) begin
		if (!RESET_N)
			pin_change_flags_q <= 4'h0;
		else
			pin_change_flags_q <= pin_change_flags_d;
	end

	assign shared_change_irq_flag = |pin_change_flags_q;

	// Status enables, software owned
	always_ff @(posedge MCLK) begin
		if (!RESET_N)
			irq_en_q <= 2'h0;
		else if (wr_irq_en)
			irq_en_q <= WDATA[1:0];
	end

	// Sticky events: bit0 any pin edge, bit1 shared flag rising
	// The set term is ORed last so an event beats a clear in the same cycle
	always_comb begin
		irq_stat_d = irq_stat_q;
		if (wr_irq_clr)
			irq_stat_d = irq_stat_q & ~WDATA[1:0];
		irq_stat_d = irq_stat_d | {(|hit) && !shared_change_irq_flag, |hit};
	end

	always_ff @(posedge MCLK) begin
		if (!RESET_N)
			irq_stat_q <= 2'h0;
		else
			irq_stat_q <= irq_stat_d;
	end

	// Edge seen one cycle back, so a check can confirm the status caught it
	always_ff @(posedge MCLK) begin
		if (!RESET_N)
			hit_any_q <= 1'b0;
		else
			hit_any_q <= |hit;
	end

	// Level interrupt: shared flag gated by its enable, plus sticky events gated by irq_en_q
	assign IRQ = (shared_change_irq_flag && shared_change_irq_enable_q) ||
		|(irq_stat_q & irq_en_q);

	always_comb begin
		rdata_d = 8'h00;
		unique case (ADDR)
			portb_edge_pkg::OFF_RISE_EN: rdata_d = {rise_edge_enable_bits_q, 4'h0};
			portb_edge_pkg::OFF_FALL_EN: rdata_d = {fall_edge_enable_bits_q, 4'h0};
			portb_edge_pkg::OFF_FLAGS: rdata_d = {pin_change_flags_q, 4'h0};
			portb_edge_pkg::OFF_CTRL: rdata_d = {6'h00, shared_change_irq_flag,
				shared_change_irq_enable_q};
			portb_edge_pkg::OFF_IRQ_STAT: rdata_d = {6'h00, irq_stat_q};
			portb_edge_pkg::OFF_IRQ_EN: rdata_d = {6'h00, irq_en_q};
			default: rdata_d = 8'h00;
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge MCLK) begin
		if (!RESET_N)
			RDATA <= 8'h00;
		else if (RD)
			RDATA <= rdata_d;
		else
			RDATA <= 8'h00;
	end

	property p_rise_sets;
		@(posedge MCLK) disable iff (!RESET_N) |rise_p |-> ##1 |pin_change_flags_q;
	endproperty
	a_rise_sets: assert property (p_rise_sets) else $error("rise lost");
	property p_fall_sets;
		@(posedge MCLK) disable iff (!RESET_N) |fall_p |-> ##1 shared_change_irq_flag;
	endproperty
	a_fall_sets: assert property (p_fall_sets) else $error("fall lost");
	property p_off;
		@(posedge MCLK) disable iff (!RESET_N)
		(rise_edge_enable_bits_q == 4'h0 && fall_edge_enable_bits_q == 4'h0)
		|=> (pin_change_flags_q & ~$past(pin_change_flags_q)) == 4'h0;
	endproperty
	a_off: assert property (p_off) else $error("edge while off");
	property p_only_by_edge;
		@(posedge MCLK) disable iff (!RESET_N)
		(pin_change_flags_q & ~$past(pin_change_flags_q)) != 4'h0 |-> $past(hit) != 4'h0;
	endproperty
	a_only_by_edge: assert property (p_only_by_edge) else $error("spurious flag");
	property p_clear;
		@(posedge MCLK) disable iff (!RESET_N)
		(WR && ADDR == portb_edge_pkg::OFF_FLAGS && WDATA == 8'h00 && hit == 4'h0)
		|-> ##1 pin_change_flags_q == 4'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("clear failed");
	property p_low_zero;
		@(posedge MCLK) disable iff (!RESET_N) $past(RD) |-> (RDATA[3:0] == 4'h0 ||
			$past(ADDR) >= portb_edge_pkg::OFF_CTRL);
	endproperty
	a_low_zero: assert property (p_low_zero) else $error("low bits nonzero");
	property p_reset;
		@(posedge MCLK) !RESET_N |-> ##1 (pin_change_flags_q == 4'h0 &&
			rise_edge_enable_bits_q == 4'h0 && fall_edge_enable_bits_q == 4'h0 &&
			irq_stat_q == 2'h0);
	endproperty
	a_reset: assert property (p_reset) else $error("reset value");
	property p_irq;
		@(posedge MCLK) disable iff (!RESET_N)
		(shared_change_irq_flag && shared_change_irq_enable_q) |-> IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing");
	c_rise: cover property (@(posedge MCLK) disable iff (!RESET_N) |rise_p ##1 IRQ);
	c_fall: cover property (@(posedge MCLK) disable iff (!RESET_N) |fall_p);
	c_clr: cover property (@(posedge MCLK) disable iff (!RESET_N)
		shared_change_irq_flag ##1 !shared_change_irq_flag);
	c_stat_clr: cover property (@(posedge MCLK) disable iff (!RESET_N)
		irq_stat_q[0] ##1 !irq_stat_q[0]);
	c_mid_reset: cover property (@(posedge MCLK) shared_change_irq_flag ##1 !RESET_N);

	// Register port; read data must reflect the state one cycle back
	property p_rd_flags;
		@(posedge MCLK) disable iff (!RESET_N)
		$past(RD) && $past(ADDR) == portb_edge_pkg::OFF_FLAGS
		|-> RDATA[7:4] == $past(pin_change_flags_q) && RDATA[3:0] == 4'h0;
	endproperty
	a_rd_flags: assert property (p_rd_flags) else $error("flag readback wrong");
	property p_rd_ctrl;
		@(posedge MCLK) disable iff (!RESET_N)
		$past(RD) && $past(ADDR) == portb_edge_pkg::OFF_CTRL
		|-> RDATA[1] == $past(shared_change_irq_flag) && RDATA[7:2] == 6'h00;
	endproperty
	a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");
	property p_rd_unmapped;
		@(posedge MCLK) disable iff (!RESET_N)
		$past(RD) && $past(ADDR) == 3'h7 |-> RDATA == 8'h00;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero");
	property p_rdata_idle;
		@(posedge MCLK) disable iff (!RESET_N) !$past(RD) |-> RDATA == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
	property p_rise_wr;
		@(posedge MCLK) disable iff (!RESET_N)
		wr_rise_en |=> {rise_edge_enable_bits_q, 4'h0} ==
			($past(WDATA) & portb_edge_pkg::IMPL_MASK);
	endproperty
	a_rise_wr: assert property (p_rise_wr) else $error("rise enable write wrong");
	property p_fall_wr;
		@(posedge MCLK) disable iff (!RESET_N)
		wr_fall_en |=> {fall_edge_enable_bits_q, 4'h0} ==
			($past(WDATA) & portb_edge_pkg::IMPL_MASK);
	endproperty
	a_fall_wr: assert property (p_fall_wr) else $error("fall enable write wrong");

	// Interrupt side
	property p_stat_any;
		@(posedge MCLK) disable iff (!RESET_N) hit_any_q |-> irq_stat_q[0];
	endproperty
	a_stat_any: assert property (p_stat_any) else $error("edge status missing");
	property p_stat_clr;
		@(posedge MCLK) disable iff (!RESET_N)
		wr_irq_clr && WDATA[0] && hit == 4'h0 |=> !irq_stat_q[0];
	endproperty
	a_stat_clr: assert property (p_stat_clr) else $error("status clear failed");
	property p_irq_quiet;
		@(posedge MCLK) disable iff (!RESET_N)
		pin_change_flags_q == 4'h0 && irq_en_q == 2'h0 |-> !IRQ;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq without cause");
	property p_irq_gated;
		@(posedge MCLK) disable iff (!RESET_N)
		!shared_change_irq_enable_q && (irq_stat_q & irq_en_q) == 2'h0 |-> !IRQ;
	endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("irq while disabled");
	property p_ctrl_wr;
		@(posedge MCLK) disable iff (!RESET_N)
		wr_ctrl && WDATA[0] |=> shared_change_irq_enable_q;
	endproperty
	a_ctrl_wr: assert property (p_ctrl_wr) else $error("irq enable not stored");
endmodule

// ### design/portb_edge_pkg.sv
package portb_edge_pkg;
	localparam int DATA_W = 8;
	localparam int PIN_LO = 4;
	localparam int PIN_N = 4;
	localparam logic [2:0] OFF_RISE_EN = 3'h0;
	localparam logic [2:0] OFF_FALL_EN = 3'h1;
	localparam logic [2:0] OFF_FLAGS = 3'h2;
	localparam logic [2:0] OFF_CTRL = 3'h3;
	localparam logic [2:0] OFF_IRQ_STAT = 3'h4;
	localparam logic [2:0] OFF_IRQ_EN = 3'h5;
	localparam logic [2:0] OFF_IRQ_CLR = 3'h6;
	localparam int CTRL_IRQ_EN_BIT = 0;
	localparam int CTRL_IRQ_FLAG_BIT = 1;
	localparam logic [7:0] RESET_VAL = 8'h00;
	localparam logic [7:0] IMPL_MASK = 8'hf0;
endpackage

// ### tb/pin_source.sv
`timescale 1ns/1ps
module pin_source (
	// Clock
	input wire logic clk,
	// Wanted and driven levels
	input wire logic [3:0] level,
	output logic [3:0] pins
);
	// Pins follow the wanted level one edge later; the bench keeps it low in the first reset and high in the mid-run one
	always_ff @(posedge clk) begin
		pins <= level;
	end
endmodule

// ### tb/portb_edge_change_detect_tb.sv
`timescale 1ns/1ps
module portb_edge_change_detect_tb;
	logic MCLK = 1'b0;
	logic RESET_N = 1'b0;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic [2:0] ADDR = 3'h0;
	logic [7:0] WDATA = 8'h00;
	logic [3:0] lvl = 4'h0;
	logic [3:0] pins;
	logic [7:0] RDATA;
	logic IRQ;
	int fails = 0;
	int compares = 0;
	initial begin
		forever #2.5 MCLK = ~MCLK;
	end
	pin_source pin_source_i (.clk(MCLK), .level(lvl), .pins(pins));
	portb_edge_change_detect portb_edge_change_detect_i (.MCLK(MCLK), .RESET_N(RESET_N),
		.UPPER_PORT_PIN(pins), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .IRQ(IRQ));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge MCLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge MCLK);
		WR <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge MCLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge MCLK);
		RD <= 1'b0;
		#1;
		chk(RDATA, exp);
	endtask
	task irq_is(input logic e);
		#1;
		chk({7'h00, IRQ}, {7'h00, e});
	endtask
	// Two synchroniser flops plus the pin model's own edge
	task pins_to(input logic [3:0] v);
		@(posedge MCLK);
		lvl <= v;
		repeat (6) @(posedge MCLK);
	endtask
	task t_reset;
		rd(portb_edge_pkg::OFF_RISE_EN, portb_edge_pkg::RESET_VAL);
		rd(portb_edge_pkg::OFF_FALL_EN, portb_edge_pkg::RESET_VAL);
		rd(portb_edge_pkg::OFF_FLAGS, portb_edge_pkg::RESET_VAL);
		irq_is(1'b0);
	endtask
	task t_regs;
		wr(portb_edge_pkg::OFF_RISE_EN, 8'hff);
		wr(portb_edge_pkg::OFF_FALL_EN, 8'h0f);
		wr(portb_edge_pkg::OFF_FLAGS, 8'hff);
		rd(portb_edge_pkg::OFF_RISE_EN, portb_edge_pkg::IMPL_MASK);
		rd(portb_edge_pkg::OFF_FALL_EN, 8'h00);
		rd(portb_edge_pkg::OFF_FLAGS, 8'h00);
		rd(3'h7, 8'h00);
	endtask
	task t_rise;
		wr(portb_edge_pkg::OFF_RISE_EN, 8'h50);
		pins_to(4'hf);
		rd(portb_edge_pkg::OFF_FLAGS, 8'h50);
		wr(portb_edge_pkg::OFF_CTRL, 8'h01);
		irq_is(1'b1);
		rd(portb_edge_pkg::OFF_CTRL, 8'h03);
	endtask
	task t_clear;
		wr(portb_edge_pkg::OFF_FLAGS, 8'h40);
		rd(portb_edge_pkg::OFF_FLAGS, 8'h40);
		wr(portb_edge_pkg::OFF_FLAGS, 8'h00);
		rd(portb_edge_pkg::OFF_FLAGS, 8'h00);
		irq_is(1'b0);
	endtask
	task t_fall_irq;
		wr(portb_edge_pkg::OFF_FALL_EN, 8'ha0);
		pins_to(4'h0);
		rd(portb_edge_pkg::OFF_FLAGS, 8'ha0);
		wr(portb_edge_pkg::OFF_CTRL, 8'h00);
		wr(portb_edge_pkg::OFF_FLAGS, 8'h00);
		rd(portb_edge_pkg::OFF_IRQ_STAT, 8'h03);
		irq_is(1'b0);
		wr(portb_edge_pkg::OFF_IRQ_EN, 8'h03);
		irq_is(1'b1);
		wr(portb_edge_pkg::OFF_IRQ_CLR, 8'h03);
		rd(portb_edge_pkg::OFF_IRQ_STAT, 8'h00);
		irq_is(1'b0);
	endtask
	// A reset in mid-run must clear everything; pins stay high across it
	task t_mid_reset;
		wr(portb_edge_pkg::OFF_RISE_EN, 8'hf0);
		wr(portb_edge_pkg::OFF_FALL_EN, 8'hf0);
		wr(portb_edge_pkg::OFF_IRQ_EN, 8'h03);
		pins_to(4'hf);
		rd(portb_edge_pkg::OFF_FLAGS, 8'hf0);
		irq_is(1'b1);
		@(posedge MCLK);
		RESET_N <= 1'b0;
		repeat (3) @(posedge MCLK);
		RESET_N <= 1'b1;
		rd(portb_edge_pkg::OFF_RISE_EN, portb_edge_pkg::RESET_VAL);
		rd(portb_edge_pkg::OFF_FALL_EN, portb_edge_pkg::RESET_VAL);
		rd(portb_edge_pkg::OFF_FLAGS, portb_edge_pkg::RESET_VAL);
		rd(portb_edge_pkg::OFF_CTRL, 8'h00);
		rd(portb_edge_pkg::OFF_IRQ_EN, 8'h00);
		irq_is(1'b0);
		pins_to(4'h0);
		rd(portb_edge_pkg::OFF_FLAGS, 8'h00);
		rd(portb_edge_pkg::OFF_IRQ_STAT, 8'h00);
	endtask
	task end_of_test;
		$display("fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge MCLK);
		RESET_N <= 1'b1;
		t_reset;
		t_regs;
		t_rise;
		t_clear;
		t_fall_irq;
		t_mid_reset;
		end_of_test;
	end
	// The tests need under two hundred cycles; this allows about four thousand
	initial begin
		#20000;
		fails++;
		end_of_test;
	end
endmodule
